// ==== host_model.sv ====
// host-side model of the register port, stands in for the serial front end
// assumes it shares CORE_CLK with the block and drives 1 ns after each edge
`timescale 1ns/1ps
`default_nettype none

module host_model (
	input wire logic clk,
	output logic [5:0] addr,
	output logic wr,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	initial begin
		addr = 6'h00;
		wr = 1'b0;
		wdata = 8'h00;
	end

	// one-cycle strobe; data flipped once released so stale bytes never look valid
	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
		wdata = ~d;
	endtask

	// address taken at one edge, byte shows after it
	task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		@(posedge clk);
		#1;
		d = rdata;
	endtask
endmodule

`default_nettype wire

// ==== rx_modem_cfg.sv ====
// configuration registers of the receiver modem and rx control machine
// assumes all inputs come from logic on CORE_CLK (serial front end, radio fsm)
`timescale 1ns/1ps
`default_nettype none

module rx_modem_cfg
	import rxcfg_pkg::*;
#(
	parameter int BASE_W = 24,
	parameter int CHANNEL_W = 8
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic [5:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	input wire logic [BASE_W-1:0] BASE_FREQ,
	input wire logic [CHANNEL_W-1:0] CHANNEL_INDEX,
	input wire logic [2:0] MOD_FORMAT,
	input wire logic RX_START,
	input wire logic RX_ACTIVE,
	input wire logic SYMBOL_TICK,
	input wire logic CARRIER_SENSE,
	input wire logic PACKET_DONE,
	output logic [BASE_W+CHANNEL_W+4:0] TUNED_FREQ,
	output logic [2:0] DEV_EXPONENT,
	output logic [2:0] DEV_MANTISSA,
	output logic DEV_ENABLE,
	output logic RX_TIMEOUT,
	output logic STAY_IN_RX,
	output logic GO_IDLE
);

	localparam int STEP_W = 12;
	localparam int FREQ_W = BASE_W + CHANNEL_W + 5;

	// -----------------------------------------------------------------
	// register storage
	// -----------------------------------------------------------------
	logic [1:0] spc_exp_q;
	logic spc_hi_q;
	logic [7:0] spc_mant_q;
	logic [2:0] dev_e_q;
	logic [2:0] dev_m_q;
	logic term_en_q;
	logic [3:0] term_lo_q;
	logic [1:0] exit_hi_q;
	logic [1:0] exit_sel_q;
	logic [1:0] exit_lo_q;
	logic [7:0] rdata_q;

	// address decode as named write strobes
	wire wr_exp = REG_WR && (REG_ADDR == SPC_EXP_OFS);
	wire wr_mant = REG_WR && (REG_ADDR == SPC_MANT_OFS);
	wire wr_dev = REG_WR && (REG_ADDR == DEV_OFS);
	wire wr_term = REG_WR && (REG_ADDR == TERM_OFS);
	wire wr_exit = REG_WR && (REG_ADDR == EXIT_OFS);

	// writable fields only; unused bits have no storage at all
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			spc_exp_q <= SPC_EXP_RST;
			spc_hi_q <= SPC_HI_RST;
			spc_mant_q <= SPC_MANT_RST;
			dev_e_q <= DEV_E_RST;
			dev_m_q <= DEV_M_RST;
			term_en_q <= TERM_EN_RST;
			term_lo_q <= TERM_LO_RST;
			exit_hi_q <= EXIT_HI_RST;
			exit_sel_q <= EXIT_SEL_RST;
			exit_lo_q <= EXIT_LO_RST;
		end else begin
			if (wr_exp) begin
				spc_exp_q <= REG_WDATA[SPC_EXP_LSB +: 2];
				spc_hi_q <= REG_WDATA[SPC_HI_POS];
			end
			if (wr_mant) begin
				spc_mant_q <= REG_WDATA;
			end
			if (wr_dev) begin
				dev_e_q <= REG_WDATA[DEV_E_LSB +: 3];
				dev_m_q <= REG_WDATA[DEV_M_LSB +: 3];
			end
			if (wr_term) begin
				term_en_q <= REG_WDATA[TERM_EN_POS];
				term_lo_q <= REG_WDATA[TERM_LO_LSB +: 4];
			end
			if (wr_exit) begin
				exit_hi_q <= REG_WDATA[EXIT_HI_LSB +: 2];
				exit_sel_q <= REG_WDATA[EXIT_SEL_LSB +: 2];
				exit_lo_q <= REG_WDATA[EXIT_LO_LSB +: 2];
			end
		end
	end

	// -----------------------------------------------------------------
	// read path: one cycle latency, unused bits and unmapped read zero
	// -----------------------------------------------------------------
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (REG_ADDR == SPC_EXP_OFS) begin
			rd_mux = {spc_hi_q, 5'h00, spc_exp_q};
		end else if (REG_ADDR == SPC_MANT_OFS) begin
			rd_mux = spc_mant_q;
		end else if (REG_ADDR == DEV_OFS) begin
			rd_mux = {1'b0, dev_e_q, 1'b0, dev_m_q};
		end else if (REG_ADDR == TERM_OFS) begin
			rd_mux = {3'h0, term_en_q, term_lo_q};
		end else if (REG_ADDR == EXIT_OFS) begin
			rd_mux = {2'h0, exit_hi_q, exit_sel_q, exit_lo_q};
		end
	end

	// -----------------------------------------------------------------
	// frequency: units of fxosc/2^18, so base is shifted left by two
	// -----------------------------------------------------------------
	wire [8:0] mant_sum = MANT_OFFSET + {1'b0, spc_mant_q};
	wire [STEP_W-1:0] step_word = {3'h0, mant_sum} << spc_exp_q;
	// both factors widened first so the product is never cut to 12 bits
	wire [FREQ_W-1:0] channel_ofs = FREQ_W'(step_word) * FREQ_W'(CHANNEL_INDEX);
	wire [FREQ_W-1:0] tuned_d = FREQ_W'({BASE_FREQ, 2'b00}) + channel_ofs;
	logic [FREQ_W-1:0] tuned_q;

	// deviation goes to the demodulator for every format except ook
	wire is_ook = (MOD_FORMAT == MOD_OOK);
	wire dev_en_d = !is_ook;
	wire [2:0] dev_e_d = is_ook ? 3'h0 : dev_e_q;
	wire [2:0] dev_m_d = is_ook ? 3'h0 : dev_m_q;
	logic dev_en_q;
	logic [2:0] dev_e_out_q;
	logic [2:0] dev_m_out_q;

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			rdata_q <= 8'h00;
			tuned_q <= '0;
			dev_en_q <= 1'b0;
			dev_e_out_q <= 3'h0;
			dev_m_out_q <= 3'h0;
		end else begin
			rdata_q <= rd_mux;
			tuned_q <= tuned_d;
			dev_en_q <= dev_en_d;
			dev_e_out_q <= dev_e_d;
			dev_m_out_q <= dev_m_d;
		end
	end

	// -----------------------------------------------------------------
	// carrier-sense watchdog for on-off keying
	// -----------------------------------------------------------------
	// armed only at rx start so a mid-frame register write cannot fire it
	watch_e watch_q;
	watch_e watch_d;
	logic [3:0] sym_cnt_q;
	logic [3:0] sym_cnt_d;
	logic timeout_d;
	logic timeout_q;

	always_comb begin
		watch_d = watch_q;
		sym_cnt_d = sym_cnt_q;
		timeout_d = 1'b0;
		case (watch_q)
			WAIT_IDLE: begin
				if (RX_START && term_en_q && is_ook) begin
					watch_d = WAIT_CARRIER;
					sym_cnt_d = 4'h0;
				end
			end
			WAIT_CARRIER: begin
				if (!RX_ACTIVE || CARRIER_SENSE) begin
					watch_d = WAIT_IDLE;
				end else if (SYMBOL_TICK) begin
					sym_cnt_d = sym_cnt_q + 4'h1;
					if (sym_cnt_q == OOK_WAIT_SYMBOLS - 4'h1) begin
						timeout_d = 1'b1;
						watch_d = WAIT_IDLE;
					end
				end
			end
			default: watch_d = WAIT_IDLE;
		endcase
	end

	// post-packet choice; reserved codes fall back to idle
	wire stay_d = PACKET_DONE && (exit_sel_q == EXIT_STAY_RX);
	wire idle_d = PACKET_DONE && (exit_sel_q != EXIT_STAY_RX);
	logic stay_q;
	logic idle_q;

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			watch_q <= WAIT_IDLE;
			sym_cnt_q <= 4'h0;
			timeout_q <= 1'b0;
			stay_q <= 1'b0;
			idle_q <= 1'b0;
		end else begin
			watch_q <= watch_d;
			sym_cnt_q <= sym_cnt_d;
			timeout_q <= timeout_d;
			stay_q <= stay_d;
			idle_q <= idle_d;
		end
	end

	assign REG_RDATA = rdata_q;
	assign TUNED_FREQ = tuned_q;
	assign DEV_ENABLE = dev_en_q;
	assign DEV_EXPONENT = dev_e_out_q;
	assign DEV_MANTISSA = dev_m_out_q;
	assign RX_TIMEOUT = timeout_q;
	assign STAY_IN_RX = stay_q;
	assign GO_IDLE = idle_q;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);

	property p_step;
		1 |=> TUNED_FREQ == FREQ_W'({$past(BASE_FREQ), 2'b00})
			+ FREQ_W'({3'h0, $past(mant_sum)} << $past(spc_exp_q)) * FREQ_W'($past(CHANNEL_INDEX));
	endproperty
	a_step: assert property (p_step) else $error("tuned word wrong");
	property p_base;
		$stable(CHANNEL_INDEX) && CHANNEL_INDEX == '0 |=> TUNED_FREQ == FREQ_W'({$past(BASE_FREQ), 2'b00});
	endproperty
	a_base: assert property (p_base) else $error("channel zero not base");
	property p_exp_rb;
		wr_exp ##1 REG_ADDR == SPC_EXP_OFS |=> REG_RDATA[1:0] == $past(REG_WDATA[1:0], 2);
	endproperty
	a_exp_rb: assert property (p_exp_rb) else $error("exponent readback");
	property p_mant_rb;
		wr_mant ##1 REG_ADDR == SPC_MANT_OFS |=> REG_RDATA == $past(REG_WDATA, 2);
	endproperty
	a_mant_rb: assert property (p_mant_rb) else $error("mantissa readback");
	property p_dev_rb;
		REG_ADDR == DEV_OFS |=> REG_RDATA[6:4] == $past(dev_e_q) && REG_RDATA[2:0] == $past(dev_m_q);
	endproperty
	a_dev_rb: assert property (p_dev_rb) else $error("deviation readback");
	property p_ook_dev;
		is_ook |=> !DEV_ENABLE && DEV_EXPONENT == 3'h0 && DEV_MANTISSA == 3'h0;
	endproperty
	a_ook_dev: assert property (p_ook_dev) else $error("deviation used in ook");
	property p_no_arm;
		!term_en_q && watch_q == WAIT_IDLE |=> watch_q == WAIT_IDLE;
	endproperty
	a_no_arm: assert property (p_no_arm) else $error("watchdog armed while off");
	sequence s_armed;
		watch_q == WAIT_CARRIER && sym_cnt_q == 4'h7;
	endsequence
	sequence s_last_tick;
		SYMBOL_TICK && RX_ACTIVE && !CARRIER_SENSE;
	endsequence
	property p_timeout;
		s_armed and s_last_tick |=> RX_TIMEOUT ##1 !RX_TIMEOUT;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout not after 8 symbols");
	property p_exit;
		PACKET_DONE |=> (STAY_IN_RX == ($past(exit_sel_q) == EXIT_STAY_RX)) && (GO_IDLE != STAY_IN_RX);
	endproperty
	a_exit: assert property (p_exit) else $error("wrong post-packet state");
	property p_zero_bits;
		REG_ADDR == SPC_EXP_OFS |=> REG_RDATA[6:2] == 5'h00;
	endproperty
	a_zero_bits: assert property (p_zero_bits) else $error("unused bits not zero");
	property p_undoc;
		wr_term ##1 REG_ADDR == TERM_OFS |=> REG_RDATA[3:0] == $past(REG_WDATA[3:0], 2);
	endproperty
	a_undoc: assert property (p_undoc) else $error("undocumented field lost");

endmodule

`default_nettype wire

// ==== rxcfg_pkg.sv ====
// constants shared by the receiver modem and rx-control configuration block
// assumes a 6-bit register address as delivered by the serial port front end
package rxcfg_pkg;

	// -----------------------------------------------------------------
	// register offsets
	// -----------------------------------------------------------------
	localparam logic [5:0] SPC_EXP_OFS = 6'h13;
	localparam logic [5:0] SPC_MANT_OFS = 6'h14;
	localparam logic [5:0] DEV_OFS = 6'h15;
	localparam logic [5:0] TERM_OFS = 6'h16;
	localparam logic [5:0] EXIT_OFS = 6'h17;

	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int SPC_EXP_LSB = 0;
	localparam int SPC_HI_POS = 7;
	localparam int DEV_M_LSB = 0;
	localparam int DEV_E_LSB = 4;
	localparam int TERM_LO_LSB = 0;
	localparam int TERM_EN_POS = 4;
	localparam int EXIT_LO_LSB = 0;
	localparam int EXIT_SEL_LSB = 2;
	localparam int EXIT_HI_LSB = 4;

	// -----------------------------------------------------------------
	// reset values
	// -----------------------------------------------------------------
	localparam logic [1:0] SPC_EXP_RST = 2'h2;
	localparam logic SPC_HI_RST = 1'b0;
	localparam logic [7:0] SPC_MANT_RST = 8'hf8;
	localparam logic [2:0] DEV_E_RST = 3'h4;
	localparam logic [2:0] DEV_M_RST = 3'h7;
	localparam logic TERM_EN_RST = 1'b0;
	localparam logic [3:0] TERM_LO_RST = 4'h7;
	localparam logic [1:0] EXIT_HI_RST = 2'h3;
	localparam logic [1:0] EXIT_SEL_RST = 2'h0;
	localparam logic [1:0] EXIT_LO_RST = 2'h0;

	// -----------------------------------------------------------------
	// encodings and counts
	// -----------------------------------------------------------------
	localparam logic [8:0] MANT_OFFSET = 9'h100;
	localparam logic [2:0] MOD_OOK = 3'h3;
	localparam logic [1:0] EXIT_STAY_RX = 2'h3;
	localparam logic [3:0] OOK_WAIT_SYMBOLS = 4'h8;

	typedef enum logic {WAIT_IDLE, WAIT_CARRIER} watch_e;

endpackage

// ==== tb_receiver_modem_and_rx_control_config.sv ====
// self-checking bench for the modem and rx-control configuration block
// assumes host_model.sv and the design files are compiled before it
`timescale 1ns/1ps
`default_nettype none

module tb_receiver_modem_and_rx_control_config
	import rxcfg_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [5:0] addr;
	logic wr;
	logic [7:0] wdata, rdata, d;
	logic [23:0] base = 24'h0;
	logic [7:0] channel = 8'h0;
	logic [2:0] mod = 3'h0;
	logic rx_start = 1'b0, rx_act = 1'b0, tick = 1'b0, cs = 1'b0, pdone = 1'b0;
	logic [36:0] tuned;
	logic [2:0] dev_e, dev_m;
	logic dev_en, tout, stay, idle;
	logic [31:0] seed = 32'ha806b925;
	int error_cnt = 0;
	int comparisons = 0;
	int mdl[5] = '{8'h02, 8'hf8, 8'h47, 8'h07, 8'h30};
	int msk[5] = '{8'h83, 8'hff, 8'h77, 8'h1f, 8'h3f};
	longint ef;

	always #25 clk = ~clk;

	host_model host_model_i (.clk(clk), .addr(addr), .wr(wr), .wdata(wdata), .rdata(rdata));
	rx_modem_cfg rx_modem_cfg_i (.CORE_CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WR(wr),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .BASE_FREQ(base), .CHANNEL_INDEX(channel),
		.MOD_FORMAT(mod), .RX_START(rx_start), .RX_ACTIVE(rx_act), .SYMBOL_TICK(tick),
		.CARRIER_SENSE(cs), .PACKET_DONE(pdone), .TUNED_FREQ(tuned), .DEV_EXPONENT(dev_e),
		.DEV_MANTISSA(dev_m), .DEV_ENABLE(dev_en), .RX_TIMEOUT(tout), .STAY_IN_RX(stay),
		.GO_IDLE(idle));

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic cmp_out(input logic [36:0] g, input logic [36:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// model copy keeps only the writable bits
	task automatic wm(input int i, input logic [7:0] v);
		host_model_i.wr_reg(SPC_EXP_OFS + 6'(i), v);
		mdl[i] = v & msk[i];
	endtask

	task automatic chk_regs();
		for (int i = 0; i < 5; i++) begin
			host_model_i.rd_reg(SPC_EXP_OFS + 6'(i), d);
			cmp_out(37'(d), 37'(mdl[i]));
		end
		host_model_i.rd_reg(6'h20, d);
		cmp_out(37'(d), 37'h0);
	endtask

	// arm the watch, tick n symbols, count timeout pulses
	task automatic wd(input logic en, input logic [2:0] mf, input int n, input logic c,
		input int e);
		int cnt;
		int early;
		cnt = 0;
		early = 0;
		wm(3, {3'h0, en, 4'h7});
		mod = mf;
		rx_act = 1'b1;
		rx_start = 1'b1;
		@(posedge clk);
		#1;
		rx_start = 1'b0;
		cs = c;
		for (int i = 0; i < 12; i++) begin
			tick = (i < n);
			@(posedge clk);
			#1;
			cnt += (tout === 1'b1);
			// sample i sees the edge of tick i+1, so the 8th tick shows at i=7
			early += (tout === 1'b1 && i < 7);
		end
		rx_act = 1'b0;
		cs = 1'b0;
		cmp_out(37'(cnt), 37'(e));
		cmp_out(37'(early), 37'h0);
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		#1;
		nrst = 1'b1;
		chk_regs();
		$display("test reset_values done");
		// unmapped write must not alias onto any register
		host_model_i.wr_reg(6'h20, 8'hff);
		for (int i = 0; i < 5; i++) wm(i, 8'hff);
		chk_regs();
		for (int i = 0; i < 10; i++) wm(i % 5, 8'(xs()));
		chk_regs();
		$display("test register_access done");
		for (int e = 0; e < 4; e++) begin
			base = 24'(xs());
			channel = (e == 3) ? 8'hff : 8'(xs());
			wm(0, {1'(xs()), 5'h0, 2'(e)});
			wm(1, (e == 3) ? 8'hff : 8'(xs()));
			repeat (2) @(posedge clk);
			#1;
			ef = longint'(base) * 4 + longint'(channel) * ((256 + mdl[1]) << e);
			cmp_out(tuned, 37'(ef));
		end
		$display("test channel_step done");
		wm(2, 8'(xs()));
		for (int j = 0; j < 8; j++) begin
			mod = 3'(j);
			repeat (2) @(posedge clk);
			#1;
			cmp_out({29'h0, dev_en, dev_e, 1'b0, dev_m}, (j == 3) ? 37'h0 :
				37'(mdl[2] & 8'h77 | 8'h80));
		end
		$display("test deviation done");
		wd(1'b1, MOD_OOK, 8, 1'b0, 1);
		wd(1'b1, MOD_OOK, 7, 1'b0, 0);
		wd(1'b1, MOD_OOK, 8, 1'b1, 0);
		wd(1'b0, MOD_OOK, 8, 1'b0, 0);
		wd(1'b1, 3'h0, 8, 1'b0, 0);
		$display("test rx_watch done");
		for (int c = 0; c < 4; c++) begin
			int ni;
			int ns;
			ni = 0;
			ns = 0;
			wm(4, {2'h0, 2'h3, 2'(c), 2'(xs())});
			pdone = 1'b1;
			repeat (3) begin
				@(posedge clk);
				#1;
				pdone = 1'b0;
				ni += (idle === 1'b1);
				ns += (stay === 1'b1);
			end
			cmp_out(37'(ni), 37'(c != 3));
			cmp_out(37'(ns), 37'(c == 3));
		end
		$display("test post_packet done");
		stop_test();
	end

	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#(50 * 6000);
		error_cnt++;
		stop_test();
	end
endmodule

`default_nettype wire
